/* pva_pkg.sv */
package pva_pkg;
  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_ISOLATION = 8'h00;
  localparam logic [7:0] ADDR_COMMUNITY = 8'h04;
  localparam logic [7:0] ADDR_AGING = 8'h08;
  localparam logic [7:0] ADDR_TABLE_OPT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_TABLE_CMD = 8'h1c;
  localparam logic [7:0] ADDR_READ_DATA = 8'h20;

  localparam int PORTS = 27;
  localparam logic [26:0] ISOLATION_RESET = 27'h07fffff;
  localparam logic [26:0] COMMUNITY_RESET = 27'h7ffffff;

  // Aging control fields
  localparam int FAST_AGE_UNIT_BIT = 21;
  localparam int AGE_INTERVAL_LSB = 1;
  localparam int AGE_INTERVAL_W = 20;
  localparam int AGE_LOCKED_BIT = 0;
  // Table options fields
  localparam int REDUCED_BIT = 1;
  localparam int SHADOW_BIT = 0;
  // Status bit for a finished aging pass
  localparam int PASS_DONE_BIT = 24;
  localparam int STATUS_W = 25;

  // Time units
  localparam int CLK_MHZ = 100;
  localparam int FAST_UNIT_NS = 8200;
  localparam int FAST_UNIT_CYC = FAST_UNIT_NS * CLK_MHZ / 1000;
  localparam int SECOND_CYC_DEF = 100000000;

  // MAC table geometry
  localparam int ROWS = 1024;
  localparam int ROWS_REDUCED = 64;
  localparam int ROW_W = 10;
  localparam int ENTRY_W = 32;
  // Entry flags
  localparam int VALID_BIT = 31;
  localparam int LOCKED_BIT = 30;
  localparam int AGED_BIT = 29;

  // Table command fields: [13:12] cmd, [11:2] row, [1:0] bucket
  localparam int CMD_LSB = 12;
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;

  typedef enum logic [1:0] {
    PVA_PROMISC,
    PVA_COMMUNITY,
    PVA_ISOLATED
  } pva_port_kind_e;

  // One frame's classification for the mask computation
  typedef struct packed {
    logic valid;
    logic private_vlan_flag;
    logic [4:0] src_port;
    logic [26:0] vlan_mask;
  } pva_frame_s;

  typedef struct packed {
    logic valid;
    logic [26:0] mask;
  } pva_result_s;
endpackage : pva_pkg

/* pva_top.sv */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module pva_top #(
  parameter int SECOND_CYC = pva_pkg::SECOND_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pva_pkg::pva_frame_s frame_in,
  output pva_pkg::pva_result_s result_out,
  output logic irq
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Byte-lane merge, used by the configuration registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  logic [26:0] isolation_mask_q;
  logic [26:0] community_mask_q;
  logic [21:0] aging_q;
  logic [1:0] topt_q;
  logic [pva_pkg::STATUS_W-1:0] status_q;
  logic [pva_pkg::STATUS_W-1:0] irq_en_q;
  logic [31:0] rd_data_q;

  // Write channel capture: address and data in either order
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic wr_hit;

  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_full_q && !s_axi_awready;
      s_axi_wready <= !w_full_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end

  // Write address decode
  always_comb
  begin
    if (aw_addr_q == pva_pkg::ADDR_ISOLATION)
      wr_hit = 1'b1;
    else if (aw_addr_q == pva_pkg::ADDR_COMMUNITY)
      wr_hit = 1'b1;
    else if (aw_addr_q == pva_pkg::ADDR_AGING)
      wr_hit = 1'b1;
    else if (aw_addr_q == pva_pkg::ADDR_TABLE_OPT)
      wr_hit = 1'b1;
    else if (aw_addr_q == pva_pkg::ADDR_IRQ_CLEAR)
      wr_hit = 1'b1;
    else if (aw_addr_q == pva_pkg::ADDR_IRQ_ENABLE)
      wr_hit = 1'b1;
    else if (aw_addr_q == pva_pkg::ADDR_TABLE_CMD
             || aw_addr_q == pva_pkg::ADDR_READ_DATA)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OK : RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      isolation_mask_q <= pva_pkg::ISOLATION_RESET;
      community_mask_q <= pva_pkg::COMMUNITY_RESET;
      aging_q <= 22'h0;
      topt_q <= 2'h0;
      irq_en_q <= '0;
    end
    else if (wr_go)
    begin
      if (aw_addr_q == pva_pkg::ADDR_ISOLATION)
        isolation_mask_q <= 27'(merge({5'h0, isolation_mask_q}, w_data_q,
                                      w_strb_q));
      else if (aw_addr_q == pva_pkg::ADDR_COMMUNITY)
        community_mask_q <= 27'(merge({5'h0, community_mask_q}, w_data_q,
                                      w_strb_q));
      else if (aw_addr_q == pva_pkg::ADDR_AGING)
        aging_q <= 22'(merge({10'h0, aging_q}, w_data_q, w_strb_q));
      else if (aw_addr_q == pva_pkg::ADDR_TABLE_OPT)
        topt_q <= 2'(merge({30'h0, topt_q}, w_data_q, w_strb_q));
      else if (aw_addr_q == pva_pkg::ADDR_IRQ_ENABLE)
        irq_en_q <= pva_pkg::STATUS_W'(merge({7'h0, irq_en_q}, w_data_q,
                                             w_strb_q));
    end
  end

  // Private-VLAN mask: one cycle from frame to result
  logic kind_comm;
  logic kind_isol;
  always_comb
  begin
    kind_comm = !community_mask_q[frame_in.src_port];
    kind_isol = !isolation_mask_q[frame_in.src_port];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_out <= '0;
    else
    begin
      result_out.valid <= frame_in.valid;
      if (!frame_in.private_vlan_flag)
        result_out.mask <= frame_in.vlan_mask;
      else if (kind_isol)
        result_out.mask <= frame_in.vlan_mask & community_mask_q
                           & isolation_mask_q;
      else if (kind_comm)
        result_out.mask <= frame_in.vlan_mask
                           & isolation_mask_q;
      else
        result_out.mask <= frame_in.vlan_mask;
    end
  end

  // Aging timebase: unit tick, then interval count
  logic [26:0] unit_cnt_q;
  logic [19:0] ivl_cnt_q;
  logic unit_tick;
  logic [19:0] interval;
  logic pass_start;
  assign interval = aging_q[pva_pkg::AGE_INTERVAL_LSB +:
                            pva_pkg::AGE_INTERVAL_W];
  assign unit_tick = aging_q[pva_pkg::FAST_AGE_UNIT_BIT]
    ? (unit_cnt_q >= 27'(pva_pkg::FAST_UNIT_CYC - 1))
    : (unit_cnt_q >= 27'(SECOND_CYC - 1));
  // Fast unit relies on software keeping interval >= 3
  assign pass_start = unit_tick && interval != 20'h0
                      && ivl_cnt_q >= interval - 20'h1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || interval == 20'h0)
    begin
      unit_cnt_q <= '0;
      ivl_cnt_q <= '0;
    end
    else
    begin
      unit_cnt_q <= unit_tick ? '0 : unit_cnt_q + 27'h1;
      if (unit_tick)
        ivl_cnt_q <= pass_start ? '0 : ivl_cnt_q + 20'h1;
    end
  end

  // MAC table storage; software fills it through the table command register
  logic [pva_pkg::ENTRY_W-1:0] table_q [pva_pkg::ROWS][4];
  logic aging_busy_q;
  logic [pva_pkg::ROW_W-1:0] age_row_q;
  logic pass_done;
  logic [pva_pkg::ROW_W-1:0] last_row;
  assign last_row = topt_q[pva_pkg::REDUCED_BIT]
    ? pva_pkg::ROW_W'(pva_pkg::ROWS_REDUCED - 1)
    : pva_pkg::ROW_W'(pva_pkg::ROWS - 1);
  assign pass_done = aging_busy_q && age_row_q == last_row;

  // Table command decode
  logic cmd_wr;
  logic [1:0] cmd_op;
  logic [pva_pkg::ROW_W-1:0] cmd_row;
  logic [1:0] cmd_bkt;
  assign cmd_wr = wr_go && aw_addr_q == pva_pkg::ADDR_TABLE_CMD;
  assign cmd_op = w_data_q[pva_pkg::CMD_LSB +: 2];
  assign cmd_row = w_data_q[2 +: pva_pkg::ROW_W] & last_row;
  assign cmd_bkt = w_data_q[1:0];

  // Aging walk, one row per cycle; table writes during the walk are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aging_busy_q <= 1'b0;
      age_row_q <= '0;
    end
    else if (pass_start && !aging_busy_q)
    begin
      aging_busy_q <= 1'b1;
      age_row_q <= '0;
    end
    else if (aging_busy_q)
    begin
      age_row_q <= age_row_q + pva_pkg::ROW_W'(1);
      if (pass_done)
        aging_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (aging_busy_q)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (table_q[age_row_q][b][pva_pkg::VALID_BIT])
        begin
          if (table_q[age_row_q][b][pva_pkg::LOCKED_BIT])
          begin
            // Locked entries are marked only when AGE_LOCKED_BIT is set, never dropped
            if (aging_q[pva_pkg::AGE_LOCKED_BIT])
              table_q[age_row_q][b][pva_pkg::AGED_BIT] <= 1'b1;
          end
          else if (table_q[age_row_q][b][pva_pkg::AGED_BIT])
            table_q[age_row_q][b][pva_pkg::VALID_BIT] <= 1'b0;
          else
            table_q[age_row_q][b][pva_pkg::AGED_BIT] <= 1'b1;
        end
      end
    end
    else if (cmd_wr && cmd_op == pva_pkg::CMD_WRITE)
      table_q[cmd_row][cmd_bkt] <= rd_data_q;
  end

  // Table read with shadow snapshot of buckets 1 to 3
  logic [pva_pkg::ENTRY_W-1:0] shadow_q [1:3];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_data_q <= 32'h0;
      for (int i = 1; i < 4; i++)
        shadow_q[i] <= '0;
    end
    else if (cmd_wr && cmd_op == pva_pkg::CMD_READ)
    begin
      if (topt_q[pva_pkg::SHADOW_BIT] && cmd_bkt != 2'h0)
        rd_data_q <= shadow_q[cmd_bkt];
      else
        rd_data_q <= table_q[cmd_row][cmd_bkt];
      if (topt_q[pva_pkg::SHADOW_BIT] && cmd_bkt == 2'h0)
        for (int i = 1; i < 4; i++)
          shadow_q[i] <= table_q[cmd_row][i];
    end
    else if (cmd_wr && cmd_op == pva_pkg::CMD_WRITE)
      rd_data_q <= rd_data_q;
    else if (wr_go && aw_addr_q == pva_pkg::ADDR_READ_DATA)
      rd_data_q <= w_data_q;
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= '0;
    else
    begin
      if (wr_go && aw_addr_q == pva_pkg::ADDR_IRQ_CLEAR)
        status_q <= status_q & ~w_data_q[pva_pkg::STATUS_W-1:0];
      if (pass_done)
        status_q[pva_pkg::PASS_DONE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_q & irq_en_q);
  end

  // Read channel: one cycle after arvalid is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OK;
        if (s_axi_araddr == pva_pkg::ADDR_ISOLATION)
          s_axi_rdata <= {5'h0, isolation_mask_q};
        else if (s_axi_araddr == pva_pkg::ADDR_COMMUNITY)
          s_axi_rdata <= {5'h0, community_mask_q};
        else if (s_axi_araddr == pva_pkg::ADDR_AGING)
          s_axi_rdata <= {10'h0, aging_q};
        else if (s_axi_araddr == pva_pkg::ADDR_TABLE_OPT)
          s_axi_rdata <= {30'h0, topt_q};
        else if (s_axi_araddr == pva_pkg::ADDR_STATUS)
          s_axi_rdata <= {7'h0, status_q};
        else if (s_axi_araddr == pva_pkg::ADDR_IRQ_ENABLE)
          s_axi_rdata <= {7'h0, irq_en_q};
        else if (s_axi_araddr == pva_pkg::ADDR_READ_DATA)
          s_axi_rdata <= rd_data_q;
        else if (s_axi_araddr == pva_pkg::ADDR_IRQ_CLEAR
                 || s_axi_araddr == pva_pkg::ADDR_TABLE_CMD)
          s_axi_rdata <= 32'h0;
        else
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_ERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pva_top

/* pva_top_asserts.sv */
`timescale 1ns/1ps
module pva_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pva_pkg::pva_frame_s frame_in,
  input wire pva_pkg::pva_result_s result_out,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers hold until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped early");
  property p_r_next;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_next: assert property (p_r_next)
    else $error("read answer late");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy)
    else $error("read taken while answer pending");
  property p_b_code;
    s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2};
  endproperty
  a_b_code: assert property (p_b_code)
    else $error("bad write response code");
  // Frame path is one register deep
  property p_lat;
    1'b1 |=> result_out.valid == $past(frame_in.valid);
  endproperty
  a_lat: assert property (p_lat)
    else $error("result valid not one cycle after frame");
  property p_plain;
    frame_in.valid && !frame_in.private_vlan_flag
      |=> result_out.mask == $past(frame_in.vlan_mask);
  endproperty
  a_plain: assert property (p_plain)
    else $error("plain vlan mask altered");
  // Masking may only remove ports, never add
  property p_subset;
    frame_in.valid |=> (result_out.mask & ~$past(frame_in.vlan_mask)) == 27'h0;
  endproperty
  a_subset: assert property (p_subset)
    else $error("result mask wider than vlan mask");
  c_priv: cover property (frame_in.valid && frame_in.private_vlan_flag);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : pva_top_asserts

bind pva_top pva_top_asserts chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .frame_in(frame_in),
  .result_out(result_out), .irq(irq)
);

/* pva_top_tb_top.sv */
`timescale 1ns/1ps
module pva_top_tb_top;
  localparam int SEC = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awr, wr_rdy, bv, arr, rv, irq;
  logic [1:0] br, rr, rs;
  logic [31:0] rd, v, iso, com;
  logic [31:0] rnd = 32'hcc9a4aa7;
  pva_pkg::pva_result_s res;
  pva_pkg::pva_frame_s fr = '0;
  pva_pkg::pva_frame_s f;
  logic [27:0] q[$];
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rz[5] = '{32'h007fffff, 32'h07ffffff, 32'h0, 32'h0, 32'h0};
  int n_mismatch = 0, samples_checked = 0, n;

  pva_top #(.SECOND_CYC(SEC)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .frame_in(fr), .result_out(res), .irq(irq)
  );

  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;

  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lf

  // Reference mask; isolated wins over community
  function automatic logic [27:0] em(input pva_pkg::pva_frame_s g);
    logic [26:0] m;
    m = g.vlan_mask;
    if (g.private_vlan_flag && !iso[g.src_port])
      m = m & com[26:0] & iso[26:0];
    else if (g.private_vlan_flag && !com[g.src_port])
      m = m & iso[26:0];
    return {g.valid, m};
  endfunction : em

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic end_of_test();
    $display("mismatches %0d checked %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    rs = br;
    bre <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    rs = rr;
    rre <= 1'b0;
    @(posedge aclk);
  endtask : rdr

  // Table access has no done flag, so allow a few cycles
  task automatic tw(input int r, input int b, input logic [31:0] d);
    wr(pva_pkg::ADDR_READ_DATA, d);
    chk({30'h0, rs}, 32'h0);
    wr(pva_pkg::ADDR_TABLE_CMD, {18'h0, pva_pkg::CMD_WRITE, r[9:0], b[1:0]});
    repeat (4) @(posedge aclk);
  endtask : tw

  task automatic tr(input int r, input int b, output logic [31:0] d);
    wr(pva_pkg::ADDR_TABLE_CMD, {18'h0, pva_pkg::CMD_READ, r[9:0], b[1:0]});
    repeat (4) @(posedge aclk);
    rdr(pva_pkg::ADDR_READ_DATA, d);
  endtask : tr

  task automatic wirq();
    n = 0;
    while (irq !== 1'b1)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wirq

  task automatic clr();
    wr(pva_pkg::ADDR_IRQ_CLEAR, 32'h01000000);
    repeat (2) @(posedge aclk);
  endtask : clr

  // Spacing between two whole passes
  task automatic gap(input logic [31:0] ag, input int lo, input int hi);
    time t0;
    wr(pva_pkg::ADDR_AGING, ag);
    clr();
    wirq();
    // Measure pass to pass, so clear overhead does not skew the count
    t0 = $time;
    clr();
    wirq();
    n = int'(($time - t0) / 10);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask : gap

  // Hang guard, well beyond the planned run
  initial
  begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ra[i])
    begin
      rdr(ra[i], v);
      chk(v, rz[i]);
    end
    rdr(8'h24, v);
    chk({30'h0, rs}, 32'h2);
    wr(8'h3c, 32'h1);
    chk({30'h0, rs}, 32'h2);
    rnd = lf(rnd);
    iso = {5'h0, rnd[26:0]};
    rnd = lf(rnd);
    com = {5'h0, rnd[26:0]};
    wr(pva_pkg::ADDR_ISOLATION, iso);
    wr(pva_pkg::ADDR_COMMUNITY, com);
    rdr(pva_pkg::ADDR_ISOLATION, v);
    chk(v, iso);
    rdr(pva_pkg::ADDR_COMMUNITY, v);
    chk(v, com);
    for (int i = 0; i < 82; i++)
    begin
      @(posedge aclk);
      if (i >= 2) chk({4'h0, res}, {4'h0, q.pop_front()});
      if (i < 80)
      begin
        rnd = lf(rnd);
        f = {rnd[31:30], 5'(rnd[29:25] % 27), rnd[26:0]};
        fr <= f;
        q.push_back(em(f));
      end
    end
    wr(pva_pkg::ADDR_TABLE_OPT, 32'h1);
    for (int b = 0; b < 4; b++) tw(7, b, 32'h80000100 + b);
    tr(7, 0, v);
    chk(v, 32'h80000100);
    tw(7, 1, 32'h80000555);
    tr(7, 1, v);
    chk(v, 32'h80000101);
    wr(pva_pkg::ADDR_TABLE_OPT, 32'h0);
    tr(7, 1, v);
    chk(v, 32'h80000555);
    wr(pva_pkg::ADDR_IRQ_ENABLE, 32'h01000000);
    tw(5, 0, 32'h80000abc);
    tw(5, 1, 32'hc0000def);
    repeat (2000) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      wr(pva_pkg::ADDR_AGING, 32'h0000003d);
      wirq();
      wr(pva_pkg::ADDR_AGING, 32'h0);
      clr();
      tr(5, 0, v);
      chk(v & 32'he0000000, p ? 32'h20000000 : 32'ha0000000);
      tr(5, 1, v);
      chk(v & 32'he0000000, 32'he0000000);
    end
    gap(32'h0000003c, 30 * SEC - 5, 30 * SEC + 5);
    wr(pva_pkg::ADDR_TABLE_OPT, 32'h2);
    // Fast unit with the smallest legal interval of 3
    gap(32'h00200006, 3 * pva_pkg::FAST_UNIT_CYC - 5,
        3 * pva_pkg::FAST_UNIT_CYC + 5);
    wr(pva_pkg::ADDR_AGING, 32'h0);
    rdr(pva_pkg::ADDR_STATUS, v);
    chk(v, 32'h01000000);
    wr(pva_pkg::ADDR_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    clr();
    rdr(pva_pkg::ADDR_STATUS, v);
    chk(v, 32'h0);
    end_of_test();
  end
endmodule : pva_top_tb_top
